// ---- inc/ccd_defines.vh ----
// Notes on behaviour
// [R1] stage 3.1 stays low for low field (bits 7:4) plus one input cycles
// [R2] stage 3.1 stays high for high field (bits 3:0) plus one input cycles
// [R3] stage 3.1 counts both reset to 2, so it divides by six
// [R4] stage 3.2 low/high counts in its own register; low count resets to 1
// [R5] group 3 phase register: 3.2 offset high nibble, 3.1 low nibble, reset 0
// [R6] stage 3.2 bypass bit powers down counting and passes its input clock
// [R7] stage 3.1 bypass bit powers down counting and passes its input clock
// [R8] group 3 obeys chip sync while nosync is zero, ignores it when one
// [R9] group 3 force bit drives output high; needs group 3 nosync set too
// [R10] stage 3.2 starts high when its start bit is one, else low
// [R11] stage 3.1 starts high when bit 0 is one, else low
// [R12] group 3 duty correction disable bit 0; zero keeps correction on
// [R13] stage 4.1 low/high counts in bits 7:4 and 3:0; low resets to 2
// [R14] group 4 phase register: 4.2 offset bits 7:4, 4.1 bits 3:0, reset 0
// [R15] stage 4.2 low/high counts in bits 7:4 and 3:0; low resets to 1
// [R16] group 4 control bits 5 and 4 bypass stages 4.2 and 4.1
// [R17] group 4 control bit 3 selects obeying or ignoring chip sync
// [R18] group 4 control bit 2 forces output high; needs group 4 nosync set
// [R19] group 4 control bits 1 and 0 set start levels of 4.2 and 4.1
// [R20] group 4 duty correction disable bit 0; correction on at reset
// [R21] stage x.1 output clocks stage x.2, ratios multiply
// [R22] on sync release obeying groups restart at start level after phase delay
`ifndef CCD_DEFINES_VH
`define CCD_DEFINES_VH

// ----------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------
`define CCD_IDX_G3_S1_CNT 9'h199
`define CCD_IDX_G3_PHASE 9'h19a
`define CCD_IDX_G3_S2_CNT 9'h19b
`define CCD_IDX_G3_CTRL 9'h19c
`define CCD_IDX_G3_DCC 9'h19d
`define CCD_IDX_G4_S1_CNT 9'h19e
`define CCD_IDX_G4_PHASE 9'h19f
`define CCD_IDX_G4_S2_CNT 9'h1a0
`define CCD_IDX_G4_CTRL 9'h1a1
`define CCD_IDX_G4_DCC 9'h1a2
`define CCD_IDX_STATUS 9'h1a3

// ----------------------------------------
// field positions
// ----------------------------------------
`define CCD_LOW_HI 7
`define CCD_LOW_LO 4
`define CCD_HIGH_HI 3
`define CCD_HIGH_LO 0
`define CCD_CTRL_BYP2 5
`define CCD_CTRL_BYP1 4
`define CCD_CTRL_NOSYNC 3
`define CCD_CTRL_FORCE 2
`define CCD_CTRL_START2 1
`define CCD_CTRL_START1 0
`define CCD_DCC_OFF 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define CCD_RST_S1_CNT 8'h22
`define CCD_RST_S2_CNT 8'h11
`define CCD_RST_PHASE 8'h00
`define CCD_RST_CTRL 8'h00
`define CCD_RST_DCC 8'h00
`define CCD_CTRL_MASK 8'h3f

`endif

// ---- hw/ccd_top.v ----
`timescale 1ns/1ps
`include "ccd_defines.vh"

// ----------------------------------------
// one divider stage
// ----------------------------------------
module ccd_stage (
	input wire clk_i,
	input wire rst_i,
	input wire in_lvl_i,
	input wire in_rise_i,
	input wire [3:0] low_i,
	input wire [3:0] high_i,
	input wire [3:0] phase_i,
	input wire start_hi_i,
	input wire bypass_i,
	input wire hold_i,
	output wire out_o,
	output wire nxt_o,
	output wire rise_o
);
	reg out_q;
	reg out_d;
	reg [3:0] cnt_q;
	reg [3:0] cnt_d;
	reg [3:0] ph_q;
	reg [3:0] ph_d;

	always @* begin
		out_d = out_q;
		cnt_d = cnt_q;
		ph_d = ph_q;
		if (bypass_i) begin
			// counter held at zero, input level passed through
			out_d = in_lvl_i; // [R6] [R7] [R16]
			cnt_d = 4'h0;
		end else if (hold_i) begin
			out_d = start_hi_i; // [R10] [R11] [R19]
			cnt_d = 4'h0;
			ph_d = phase_i; // [R22]
		end else if (in_rise_i) begin
			if (ph_q != 4'h0) begin
				ph_d = ph_q - 4'h1; // [R22]
			end else if (cnt_q == (out_q ? high_i : low_i)) begin
				out_d = ~out_q; // [R1] [R2]
				cnt_d = 4'h0;
			end else begin
				cnt_d = cnt_q + 4'h1;
			end
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			out_q <= 1'b0;
			cnt_q <= 4'h0;
			ph_q <= 4'h0;
		end else begin
			out_q <= out_d;
			cnt_q <= cnt_d;
			ph_q <= ph_d;
		end
	end

	assign out_o = out_q;
	assign nxt_o = out_d;
	assign rise_o = out_d & ~out_q;
endmodule // ccd_stage

// ----------------------------------------
// two groups of cascaded stages with wishbone registers
// ----------------------------------------
module ccd_top (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [10:2] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire dist_clk_i,
	input wire sync_i,
	output reg grp3_out_o,
	output reg grp4_out_o,
	output reg grp3_duty_correction_disable_o,
	output reg grp4_duty_correction_disable_o
);
	reg [7:0] g3_s1_cnt_q;
	reg [7:0] g3_phase_q;
	reg [7:0] g3_s2_cnt_q;
	reg [7:0] g3_ctrl_q;
	reg [7:0] g3_dcc_q;
	reg [7:0] g4_s1_cnt_q;
	reg [7:0] g4_phase_q;
	reg [7:0] g4_s2_cnt_q;
	reg [7:0] g4_ctrl_q;
	reg [7:0] g4_dcc_q;
	reg dist_q;
	reg init_q;
	reg [7:0] rd_d;
	wire wr_en;
	wire wr_g3_s1_cnt;
	wire wr_g3_phase;
	wire wr_g3_s2_cnt;
	wire wr_g3_ctrl;
	wire wr_g3_dcc;
	wire wr_g4_s1_cnt;
	wire wr_g4_phase;
	wire wr_g4_s2_cnt;
	wire wr_g4_ctrl;
	wire wr_g4_dcc;
	wire dist_rise;
	wire g3_hold;
	wire g4_hold;
	wire g3_s1_out;
	wire g3_s1_nxt;
	wire g3_s1_rise;
	wire g3_s2_out;
	wire g3_s2_nxt;
	wire g4_s1_out;
	wire g4_s1_nxt;
	wire g4_s1_rise;
	wire g4_s2_out;
	wire g4_s2_nxt;

	// ----------------------------------------
	// wishbone slave: one wait state, ack one cycle
	// ----------------------------------------
	function ccd_hit(input [8:0] adr, input [8:0] idx);
		begin
			ccd_hit = (adr == idx);
		end
	endfunction

	// writes land at the edge where the master sees ack, never a cycle early
	assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & wb_ack_o;
	assign wr_g3_s1_cnt = wr_en & ccd_hit(wb_adr_i, `CCD_IDX_G3_S1_CNT);
	assign wr_g3_phase = wr_en & ccd_hit(wb_adr_i, `CCD_IDX_G3_PHASE);
	assign wr_g3_s2_cnt = wr_en & ccd_hit(wb_adr_i, `CCD_IDX_G3_S2_CNT);
	assign wr_g3_ctrl = wr_en & ccd_hit(wb_adr_i, `CCD_IDX_G3_CTRL);
	assign wr_g3_dcc = wr_en & ccd_hit(wb_adr_i, `CCD_IDX_G3_DCC);
	assign wr_g4_s1_cnt = wr_en & ccd_hit(wb_adr_i, `CCD_IDX_G4_S1_CNT);
	assign wr_g4_phase = wr_en & ccd_hit(wb_adr_i, `CCD_IDX_G4_PHASE);
	assign wr_g4_s2_cnt = wr_en & ccd_hit(wb_adr_i, `CCD_IDX_G4_S2_CNT);
	assign wr_g4_ctrl = wr_en & ccd_hit(wb_adr_i, `CCD_IDX_G4_CTRL);
	assign wr_g4_dcc = wr_en & ccd_hit(wb_adr_i, `CCD_IDX_G4_DCC);

	always @* begin
		case (wb_adr_i)
			`CCD_IDX_G3_S1_CNT: rd_d = g3_s1_cnt_q;
			`CCD_IDX_G3_PHASE: rd_d = g3_phase_q;
			`CCD_IDX_G3_S2_CNT: rd_d = g3_s2_cnt_q;
			`CCD_IDX_G3_CTRL: rd_d = g3_ctrl_q;
			`CCD_IDX_G3_DCC: rd_d = g3_dcc_q;
			`CCD_IDX_G4_S1_CNT: rd_d = g4_s1_cnt_q;
			`CCD_IDX_G4_PHASE: rd_d = g4_phase_q;
			`CCD_IDX_G4_S2_CNT: rd_d = g4_s2_cnt_q;
			`CCD_IDX_G4_CTRL: rd_d = g4_ctrl_q;
			`CCD_IDX_G4_DCC: rd_d = g4_dcc_q;
			`CCD_IDX_STATUS: rd_d = {2'b00, g4_hold, g3_hold, g4_s2_out, g4_s1_out, g3_s2_out, g3_s1_out};
			default: rd_d = 8'h00;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			wb_dat_o <= {24'h00_0000, rd_d};
		end
	end

	// ----------------------------------------
	// register file, one process per register
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			g3_s1_cnt_q <= `CCD_RST_S1_CNT; // [R3]
		end else if (wr_g3_s1_cnt) begin
			g3_s1_cnt_q <= wb_dat_i[7:0];
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			g3_phase_q <= `CCD_RST_PHASE; // [R5]
		end else if (wr_g3_phase) begin
			g3_phase_q <= wb_dat_i[7:0];
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			g3_s2_cnt_q <= `CCD_RST_S2_CNT; // [R4]
		end else if (wr_g3_s2_cnt) begin
			g3_s2_cnt_q <= wb_dat_i[7:0];
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			g3_ctrl_q <= `CCD_RST_CTRL;
		end else if (wr_g3_ctrl) begin
			g3_ctrl_q <= wb_dat_i[7:0] & `CCD_CTRL_MASK;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			g3_dcc_q <= `CCD_RST_DCC; // [R12]
		end else if (wr_g3_dcc) begin
			g3_dcc_q <= {7'h00, wb_dat_i[`CCD_DCC_OFF]};
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			g4_s1_cnt_q <= `CCD_RST_S1_CNT; // [R13]
		end else if (wr_g4_s1_cnt) begin
			g4_s1_cnt_q <= wb_dat_i[7:0];
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			g4_phase_q <= `CCD_RST_PHASE; // [R14]
		end else if (wr_g4_phase) begin
			g4_phase_q <= wb_dat_i[7:0];
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			g4_s2_cnt_q <= `CCD_RST_S2_CNT; // [R15]
		end else if (wr_g4_s2_cnt) begin
			g4_s2_cnt_q <= wb_dat_i[7:0];
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			g4_ctrl_q <= `CCD_RST_CTRL;
		end else if (wr_g4_ctrl) begin
			g4_ctrl_q <= wb_dat_i[7:0] & `CCD_CTRL_MASK;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			g4_dcc_q <= `CCD_RST_DCC; // [R20]
		end else if (wr_g4_dcc) begin
			g4_dcc_q <= {7'h00, wb_dat_i[`CCD_DCC_OFF]};
		end
	end

	// ----------------------------------------
	// distribution clock edge and sync hold
	// ----------------------------------------
	// init_q restarts all stages once after reset whatever nosync says
	always @(posedge clk_i) begin
		if (rst_i) begin
			dist_q <= 1'b0;
			init_q <= 1'b1;
		end else begin
			dist_q <= dist_clk_i;
			init_q <= 1'b0;
		end
	end

	assign dist_rise = dist_clk_i & ~dist_q;
	assign g3_hold = init_q | (sync_i & ~g3_ctrl_q[`CCD_CTRL_NOSYNC]); // [R8]
	assign g4_hold = init_q | (sync_i & ~g4_ctrl_q[`CCD_CTRL_NOSYNC]); // [R17]

	// ----------------------------------------
	// group 3
	// ----------------------------------------
	ccd_stage u_g3_s1 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_lvl_i(dist_clk_i),
		.in_rise_i(dist_rise),
		.low_i(g3_s1_cnt_q[`CCD_LOW_HI:`CCD_LOW_LO]), // [R1]
		.high_i(g3_s1_cnt_q[`CCD_HIGH_HI:`CCD_HIGH_LO]), // [R2]
		.phase_i(g3_phase_q[3:0]), // [R5]
		.start_hi_i(g3_ctrl_q[`CCD_CTRL_START1]), // [R11]
		.bypass_i(g3_ctrl_q[`CCD_CTRL_BYP1]), // [R7]
		.hold_i(g3_hold),
		.out_o(g3_s1_out),
		.nxt_o(g3_s1_nxt),
		.rise_o(g3_s1_rise)
	);

	// stage 2 counts the edges of stage 1
	ccd_stage u_g3_s2 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_lvl_i(g3_s1_nxt), // [R21]
		.in_rise_i(g3_s1_rise), // [R21]
		.low_i(g3_s2_cnt_q[`CCD_LOW_HI:`CCD_LOW_LO]), // [R4]
		.high_i(g3_s2_cnt_q[`CCD_HIGH_HI:`CCD_HIGH_LO]), // [R4]
		.phase_i(g3_phase_q[7:4]), // [R5]
		.start_hi_i(g3_ctrl_q[`CCD_CTRL_START2]), // [R10]
		.bypass_i(g3_ctrl_q[`CCD_CTRL_BYP2]), // [R6]
		.hold_i(g3_hold),
		.out_o(g3_s2_out),
		.nxt_o(g3_s2_nxt),
		.rise_o()
	);

	// ----------------------------------------
	// group 4
	// ----------------------------------------
	ccd_stage u_g4_s1 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_lvl_i(dist_clk_i),
		.in_rise_i(dist_rise),
		.low_i(g4_s1_cnt_q[`CCD_LOW_HI:`CCD_LOW_LO]), // [R13]
		.high_i(g4_s1_cnt_q[`CCD_HIGH_HI:`CCD_HIGH_LO]), // [R13]
		.phase_i(g4_phase_q[3:0]), // [R14]
		.start_hi_i(g4_ctrl_q[`CCD_CTRL_START1]), // [R19]
		.bypass_i(g4_ctrl_q[`CCD_CTRL_BYP1]), // [R16]
		.hold_i(g4_hold),
		.out_o(g4_s1_out),
		.nxt_o(g4_s1_nxt),
		.rise_o(g4_s1_rise)
	);

	ccd_stage u_g4_s2 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_lvl_i(g4_s1_nxt), // [R21]
		.in_rise_i(g4_s1_rise), // [R21]
		.low_i(g4_s2_cnt_q[`CCD_LOW_HI:`CCD_LOW_LO]), // [R15]
		.high_i(g4_s2_cnt_q[`CCD_HIGH_HI:`CCD_HIGH_LO]), // [R15]
		.phase_i(g4_phase_q[7:4]), // [R14]
		.start_hi_i(g4_ctrl_q[`CCD_CTRL_START2]), // [R19]
		.bypass_i(g4_ctrl_q[`CCD_CTRL_BYP2]), // [R16]
		.hold_i(g4_hold),
		.out_o(g4_s2_out),
		.nxt_o(g4_s2_nxt),
		.rise_o()
	);

	// ----------------------------------------
	// group outputs
	// ----------------------------------------
	// force only acts while the group ignores sync, so a pending
	// sync can never fight a forced level
	always @(posedge clk_i) begin
		if (rst_i) begin
			grp3_out_o <= 1'b0;
			grp4_out_o <= 1'b0;
			grp3_duty_correction_disable_o <= 1'b0;
			grp4_duty_correction_disable_o <= 1'b0;
		end else begin
			if (g3_ctrl_q[`CCD_CTRL_NOSYNC] & g3_ctrl_q[`CCD_CTRL_FORCE]) begin
				grp3_out_o <= 1'b1; // [R9]
			end else begin
				grp3_out_o <= g3_s2_nxt;
			end
			if (g4_ctrl_q[`CCD_CTRL_NOSYNC] & g4_ctrl_q[`CCD_CTRL_FORCE]) begin
				grp4_out_o <= 1'b1; // [R18]
			end else begin
				grp4_out_o <= g4_s2_nxt;
			end
			grp3_duty_correction_disable_o <= g3_dcc_q[`CCD_DCC_OFF]; // [R12]
			grp4_duty_correction_disable_o <= g4_dcc_q[`CCD_DCC_OFF]; // [R20]
		end
	end
endmodule // ccd_top

// ---- tb/ccd_properties.sv ----
`timescale 1ns/1ps
`include "ccd_defines.vh"
// ----------------------------------------
// bus and output checks
// ----------------------------------------
module ccd_props (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [10:2] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire dist_clk_i,
	input wire sync_i,
	input wire grp3_out_o,
	input wire grp4_out_o,
	input wire grp3_duty_correction_disable_o,
	input wire grp4_duty_correction_disable_o
);
	reg [7:0] c3_q;
	reg [7:0] c4_q;
	reg [1:0] d_q;
	wire wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
	// shadows move at the ack edge, the same edge as the real registers
	always @(posedge clk_i) begin
		if (rst_i) begin
			c3_q <= 8'h00;
			c4_q <= 8'h00;
			d_q <= 2'h0;
		end else if (wr) begin
			if (wb_adr_i == `CCD_IDX_G3_CTRL) c3_q <= wb_dat_i[7:0];
			if (wb_adr_i == `CCD_IDX_G4_CTRL) c4_q <= wb_dat_i[7:0];
			if (wb_adr_i == `CCD_IDX_G3_DCC) d_q[0] <= wb_dat_i[0];
			if (wb_adr_i == `CCD_IDX_G4_DCC) d_q[1] <= wb_dat_i[0];
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
	read_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	force3_high_a: assert property ((c3_q[3:2] == 2'h3) [*3] |-> grp3_out_o)
		else $error("group 3 not forced");
	force4_high_a: assert property ((c4_q[3:2] == 2'h3) [*3] |-> grp4_out_o)
		else $error("group 4 not forced");
	dcc_copy_a: assert property ((d_q == $past(d_q)) [*2] |-> {grp4_duty_correction_disable_o,
		grp3_duty_correction_disable_o} == d_q) else $error("dcc level wrong");
	hold3_level_a: assert property ((sync_i && c3_q[5:3] == 3'h0 && $stable(c3_q)) [*4]
		|-> grp3_out_o == c3_q[1]) else $error("group 3 not at start");
	hold4_level_a: assert property ((sync_i && c4_q[5:3] == 3'h0 && $stable(c4_q)) [*4]
		|-> grp4_out_o == c4_q[1]) else $error("group 4 not at start");
	bypass3_pass_a: assert property ((c3_q[5:2] == 4'hc && $stable(c3_q)) [*3]
		|-> grp3_out_o == $past(dist_clk_i)) else $error("group 3 bypass wrong");
	cov_read: cover property (wb_ack_o && !wb_we_i);
	cov_bypass: cover property (c3_q[5:4] == 2'h3 && grp3_out_o);
	cov_force: cover property (c3_q[3:2] == 2'h3 && grp3_out_o);
	cov_hold: cover property (sync_i && grp4_out_o);
endmodule // ccd_props

bind ccd_top ccd_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_dat_o, .wb_ack_o, .dist_clk_i, .sync_i, .grp3_out_o, .grp4_out_o,
	.grp3_duty_correction_disable_o, .grp4_duty_correction_disable_o);

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`include "ccd_defines.vh"
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [10:2] wb_adr_i = 9'h000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic dist_clk_i = 1'b0;
	logic sync_i = 1'b0;
	wire [31:0] wb_dat_o;
	wire wb_ack_o;
	wire grp3_out_o;
	wire grp4_out_o;
	wire [1:0] dcc;
	int bad_count = 0;
	int num_checks = 0;
	logic [7:0] rst_v [10] = '{8'h22, 8'h00, 8'h11, 8'h00, 8'h00, 8'h22, 8'h00, 8'h11, 8'h00, 8'h00};
	logic [7:0] ful_v [10] = '{8'hff, 8'hff, 8'hff, 8'h3f, 8'h01, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h01};
	ccd_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .dist_clk_i, .sync_i, .grp3_out_o, .grp4_out_o,
		.grp3_duty_correction_disable_o(dcc[0]), .grp4_duty_correction_disable_o(dcc[1]));
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	// distribution clock at half the bus clock: one input cycle is two bus cycles
	always @(posedge clk_i) dist_clk_i <= ~dist_clk_i;
	initial begin
		#200000;
		bad_count++;
		conclude;
	end
	task check(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// waits for ack however long it takes; only the watchdog ends a hang
	task acc(input logic we, input logic [8:0] a, input logic [7:0] d, output logic [31:0] q);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h00_0000, d};
		wb_sel_i <= 4'h1;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task wr(input logic [8:0] a, input logic [7:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
	endtask
	task rd(input logic [8:0] a, input logic [7:0] e);
		logic [31:0] q;
		acc(1'b0, a, 8'h00, q);
		check(q[7:0], e);
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// times the second full period after a change, so a leftover count cannot spoil it
	task automatic meas(input logic g4, input int per, input int hi);
		int k = 0;
		int t = 0;
		int h = 0;
		int n = 0;
		logic p = 1'b1;
		logic c;
		while (k < 3 && n < 600) begin
			@(posedge clk_i);
			c = g4 ? grp4_out_o : grp3_out_o;
			n++;
			if (c && !p) k++;
			if (k == 2) t++;
			if (k == 2 && c) h++;
			p = c;
		end
		check(t[7:0], per[7:0]);
		check(h[7:0], hi[7:0]);
	endtask
	task do_reset;
		rst_i <= 1'b1;
		wt(3);
		rst_i <= 1'b0;
		wt(1);
	endtask
	task t_regs;
		for (int i = 0; i < 10; i++) rd(9'h199 + i[8:0], rst_v[i]);
		for (int i = 0; i < 10; i++) wr(9'h199 + i[8:0], 8'hff);
		for (int i = 0; i < 10; i++) rd(9'h199 + i[8:0], ful_v[i]);
		wr(9'h1a4, 8'hff);
		rd(9'h1a4, 8'h00);
	endtask
	task t_ratio;
		sync_i <= 1'b1;
		wr(`CCD_IDX_G3_S1_CNT, 8'h70);
		wr(`CCD_IDX_G3_S2_CNT, 8'h10);
		wr(`CCD_IDX_G4_S1_CNT, 8'h01);
		wr(`CCD_IDX_G4_S2_CNT, 8'h00);
		sync_i <= 1'b0;
		meas(1'b0, 54, 18);
		meas(1'b1, 12, 6);
	endtask
	task t_bypass;
		wr(`CCD_IDX_G3_CTRL, 8'h30);
		meas(1'b0, 2, 1);
		wr(`CCD_IDX_G4_CTRL, 8'h10);
		meas(1'b1, 4, 2);
		wr(`CCD_IDX_G4_CTRL, 8'h20);
		meas(1'b1, 6, 4);
	endtask
	task t_hold;
		sync_i <= 1'b1;
		wr(`CCD_IDX_G3_CTRL, 8'h02);
		wr(`CCD_IDX_G4_CTRL, 8'h21);
		wt(8);
		check(grp3_out_o, 8'h01);
		check(grp4_out_o, 8'h01);
		wr(`CCD_IDX_G3_CTRL, 8'h21);
		wr(`CCD_IDX_G4_CTRL, 8'h04);
		wt(8);
		check(grp3_out_o, 8'h01);
		check(grp4_out_o, 8'h00);
		wr(`CCD_IDX_G3_CTRL, 8'h0c);
		wr(`CCD_IDX_G4_CTRL, 8'h0c);
		wt(8);
		check({grp4_out_o, grp3_out_o}, 8'h03);
		wr(`CCD_IDX_G3_CTRL, 8'h08);
		wr(`CCD_IDX_G4_CTRL, 8'h08);
		meas(1'b0, 54, 18);
		meas(1'b1, 12, 6);
		sync_i <= 1'b0;
	endtask
	task t_dcc;
		check(dcc, 8'h00);
		wr(`CCD_IDX_G3_DCC, 8'h01);
		wt(3);
		check(dcc, 8'h01);
		wr(`CCD_IDX_G4_DCC, 8'h01);
		wr(`CCD_IDX_G3_DCC, 8'h00);
		wt(3);
		check(dcc, 8'h02);
	endtask
	// both groups run 1:1 stages released together; only 4.1 waits three input cycles
	task t_phase;
		int n;
		int t3;
		int t4;
		int d;
		n = 0;
		t3 = 0;
		t4 = 0;
		wr(`CCD_IDX_G3_S1_CNT, 8'h00);
		sync_i <= 1'b1;
		wr(`CCD_IDX_G3_CTRL, 8'h00);
		wr(`CCD_IDX_G4_CTRL, 8'h00);
		wr(`CCD_IDX_G3_S2_CNT, 8'h00);
		wr(`CCD_IDX_G4_S1_CNT, 8'h00);
		wr(`CCD_IDX_G4_S2_CNT, 8'h00);
		wr(`CCD_IDX_G4_PHASE, 8'h03);
		rd(`CCD_IDX_STATUS, 8'h30);
		sync_i <= 1'b0;
		while ((t3 == 0 || t4 == 0) && n < 200) begin
			@(posedge clk_i);
			n++;
			if (grp3_out_o && t3 == 0) t3 = n;
			if (grp4_out_o && t4 == 0) t4 = n;
		end
		if (t3 == 0) d = 0;
		else d = t4 - t3;
		check(d[7:0], 8'h06);
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		@(posedge clk_i);
		do_reset;
		t_regs;
		do_reset;
		t_dcc;
		t_ratio;
		t_bypass;
		t_hold;
		t_phase;
		conclude;
	end
endmodule // tb
